// ===== design/adcic_pkg.sv
// constants shared by the input configuration register bank
package adcic_pkg;
  localparam int REG_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_W = 6;
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SRC_LEVEL = 6'h0e;
  localparam logic [IDX_W-1:0] IDX_RSVD = 6'h0f;
  localparam logic [IDX_W-1:0] IDX_AMP = 6'h10;
  localparam logic [IDX_W-1:0] IDX_INSEL = 6'h11;
  localparam logic [IDX_W-1:0] IDX_BIAS = 6'h12;
  // reset values
  localparam logic [REG_W-1:0] RST_SRC_LEVEL = 8'h00;
  localparam logic [REG_W-1:0] RST_AMP = 8'h00;
  localparam logic [REG_W-1:0] RST_INSEL = 8'hff;
  localparam logic [REG_W-1:0] RST_BIAS = 8'h00;
  localparam logic [REG_W-1:0] RSVD_VALUE = 8'h00;
  // field positions and widths
  localparam int SRC1_LSB = 0;
  localparam int SRC2_LSB = 4;
  localparam int SRC_W = 4;
  localparam int BYPASS_BIT = 7;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 3;
  localparam int NEGATIVE_INPUT_SELECT_LSB = 0;
  localparam int POSITIVE_INPUT_SELECT_LSB = 4;
  localparam int MUX_W = 4;
  localparam int BO_LSB = 0;
  localparam int BO_W = 3;
  localparam int BO_POL_BIT = 3;
  localparam int BIAS_VOLTAGE_ENABLE_BIT = 4;
  // decoded value widths
  localparam int UA_W = 12;
  localparam int NA_W = 14;
  localparam int GAIN_F_W = 8;
  localparam logic [GAIN_F_W-1:0] GAIN_UNITY = 8'h01;
  // selection codes
  localparam logic [MUX_W-1:0] MUX_OPEN = 4'he;
  localparam logic [SRC_W-1:0] SRC_CODE_MAX = 4'ha;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE  = 3'h0,
    SEL_SRC   = 3'h1,
    SEL_RSVD  = 3'h3,
    SEL_AMP   = 3'h2,
    SEL_INSEL = 3'h6,
    SEL_BIAS  = 3'h7
  } adcic_sel_t;
endpackage

// ===== design/adcic_field_decode.sv
// maps stored register codes onto analog front end quantities
`timescale 1ns/1ns
module adcic_field_decode
(
  input  wire logic [adcic_pkg::REG_W-1:0]    i_src_level,
  input  wire logic [adcic_pkg::REG_W-1:0]    i_amp,
  input  wire logic [adcic_pkg::REG_W-1:0]    i_insel,
  input  wire logic [adcic_pkg::REG_W-1:0]    i_bias,
  output logic      [adcic_pkg::UA_W-1:0]     o_src2_ua,
  output logic      [adcic_pkg::UA_W-1:0]     o_src1_ua,
  output logic      [adcic_pkg::GAIN_F_W-1:0] o_gain,
  output logic                                o_all_open,
  output logic      [adcic_pkg::NA_W-1:0]     o_bo_na
);

  // excitation code to microamps, unused codes read as off
  function automatic logic [adcic_pkg::UA_W-1:0] src_ua(input logic [adcic_pkg::SRC_W-1:0] c);
    logic [adcic_pkg::UA_W-1:0] v;
    v = 12'h000;
    unique case (c)
      4'h1:    v = 12'h032;
      4'h2:    v = 12'h064;
      4'h3:    v = 12'h0fa;
      4'h4:    v = 12'h1f4;
      4'h5:    v = 12'h2ee;
      4'h6:    v = 12'h3e8;
      4'h7:    v = 12'h5dc;
      4'h8:    v = 12'h7d0;
      4'h9:    v = 12'h9c4;
      4'ha:    v = 12'hbb8;
      default: v = 12'h000;
    endcase
    return v;
  endfunction

  assign o_src2_ua = src_ua(i_src_level[adcic_pkg::SRC2_LSB +: adcic_pkg::SRC_W]);
  assign o_src1_ua = src_ua(i_src_level[adcic_pkg::SRC1_LSB +: adcic_pkg::SRC_W]);
  assign o_gain = adcic_pkg::GAIN_UNITY << i_amp[adcic_pkg::GAIN_LSB +: adcic_pkg::GAIN_W];
  assign o_all_open = (i_insel[adcic_pkg::NEGATIVE_INPUT_SELECT_LSB +: adcic_pkg::MUX_W] == adcic_pkg::MUX_OPEN);

  // burn-out magnitude, reserved codes give no current
  always_comb
  begin
    o_bo_na = 14'h0000;
    unique case (i_bias[adcic_pkg::BO_LSB +: adcic_pkg::BO_W])
      3'h1:    o_bo_na = 14'h0032;
      3'h2:    o_bo_na = 14'h00c8;
      3'h3:    o_bo_na = 14'h03e8;
      3'h4:    o_bo_na = 14'h2710;
      default: o_bo_na = 14'h0000;
    endcase
  end

endmodule

// ===== design/adcic_regs.sv
// input configuration register bank with an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// How it works
// - The upper nibble of the magnitude register sets the second source, 50 to 3000 uA, code 0 and 11-15 off.
// - The lower nibble sets the first source with the same mapping and resets to off.
// - The reserved register always reads as zero.
// - Amplifier register bit 7 set selects amplifier bypass, clear keeps it in the path.
// - The amplifier gain field selects gain 1 to 128 in powers of two and resets to unity.
// - The positive select field picks common, inputs 0-9, temperature, supplies, open or common mode.
// - The negative select field uses the same codes and code 1110 opens all inputs.
// - The input select register resets to FFh so both inputs see the common-mode voltage.
// - The bias register resets to 00h with bias enable, polarity and burn-out level fields.
// - The bias enable bit connects the bias voltage to the common input pin when set.
// - The burn-out polarity bit is pull-up when clear and pull-down when set.
// - The burn-out level codes 0-4 give off, 50 nA, 200 nA, 1 uA and 10 uA, the rest reserved.
module adcic_regs
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic                              i_core_clk,
  input  wire logic                              i_nrst,
  input  wire logic                              i_ce,
  input  wire logic [ADDR_W-1:0]                 i_s_axi_awaddr,
  input  wire logic                              i_s_axi_awvalid,
  output logic                                   o_s_axi_awready,
  input  wire logic [adcic_pkg::DATA_W-1:0]      i_s_axi_wdata,
  input  wire logic [3:0]                        i_s_axi_wstrb,
  input  wire logic                              i_s_axi_wvalid,
  output logic                                   o_s_axi_wready,
  output logic [1:0]                             o_s_axi_bresp,
  output logic                                   o_s_axi_bvalid,
  input  wire logic                              i_s_axi_bready,
  input  wire logic [ADDR_W-1:0]                 i_s_axi_araddr,
  input  wire logic                              i_s_axi_arvalid,
  output logic                                   o_s_axi_arready,
  output logic [adcic_pkg::DATA_W-1:0]           o_s_axi_rdata,
  output logic [1:0]                             o_s_axi_rresp,
  output logic                                   o_s_axi_rvalid,
  input  wire logic                              i_s_axi_rready,
  output logic [adcic_pkg::UA_W-1:0]             o_second_source_ua,
  output logic [adcic_pkg::UA_W-1:0]             o_first_source_ua,
  output logic                                   o_amp_bypass,
  output logic [adcic_pkg::GAIN_F_W-1:0]         o_gain,
  output logic [adcic_pkg::MUX_W-1:0]            o_positive_input_select,
  output logic [adcic_pkg::MUX_W-1:0]            o_negative_input_select,
  output logic                                   o_all_inputs_open,
  output logic                                   o_bias_voltage_enable,
  output logic                                   o_burnout_polarity,
  output logic [adcic_pkg::NA_W-1:0]             o_burnout_na
);

  localparam int IW = ADDR_W - 2;

  // word index to register, low address bits ignored
  function automatic adcic_pkg::adcic_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    logic [IW-1:0] idx;
    adcic_pkg::adcic_sel_t s;
    idx = a[ADDR_W-1:2];
    s = adcic_pkg::SEL_NONE;
    if (idx == IW'(adcic_pkg::IDX_SRC_LEVEL))
      s = adcic_pkg::SEL_SRC;
    else if (idx == IW'(adcic_pkg::IDX_RSVD))
      s = adcic_pkg::SEL_RSVD;
    else if (idx == IW'(adcic_pkg::IDX_AMP))
      s = adcic_pkg::SEL_AMP;
    else if (idx == IW'(adcic_pkg::IDX_INSEL))
      s = adcic_pkg::SEL_INSEL;
    else if (idx == IW'(adcic_pkg::IDX_BIAS))
      s = adcic_pkg::SEL_BIAS;
    return s;
  endfunction

  // register storage
  logic [adcic_pkg::REG_W-1:0]  src_level_r;
  logic [adcic_pkg::REG_W-1:0]  amp_r;
  logic [adcic_pkg::REG_W-1:0]  insel_r;
  logic [adcic_pkg::REG_W-1:0]  bias_r;

  // write and read channel holding state
  logic                         aw_full_r;
  logic                         w_full_r;
  logic [ADDR_W-1:0]            awaddr_r;
  logic [adcic_pkg::REG_W-1:0]  wbyte_r;
  logic                         wlane_r;
  logic                         awready_r;
  logic                         wready_r;
  logic                         bvalid_r;
  logic [1:0]                   bresp_r;
  logic                         arready_r;
  logic                         rvalid_r;
  logic [adcic_pkg::DATA_W-1:0] rdata_r;
  logic [1:0]                   rresp_r;

  // handshake decode
  wire logic aw_hs = i_s_axi_awvalid & awready_r;
  wire logic w_hs = i_s_axi_wvalid & wready_r;
  wire logic wr_fire = aw_full_r & w_full_r & ~bvalid_r;
  wire logic aw_full_nxt = wr_fire ? 1'b0 : (aw_full_r | aw_hs);
  wire logic w_full_nxt = wr_fire ? 1'b0 : (w_full_r | w_hs);
  wire logic bvalid_nxt = wr_fire | (bvalid_r & ~i_s_axi_bready);
  wire logic ar_hs = i_s_axi_arvalid & arready_r;
  wire logic rvalid_nxt = ar_hs | (rvalid_r & ~i_s_axi_rready);

  // write target, only byte lane 0 carries register data
  wire adcic_pkg::adcic_sel_t wr_sel = reg_sel(awaddr_r);
  wire logic wr_en = wr_fire & wlane_r;
  wire logic wr_src = wr_en & (wr_sel == adcic_pkg::SEL_SRC);
  wire logic wr_amp = wr_en & (wr_sel == adcic_pkg::SEL_AMP);
  wire logic wr_insel = wr_en & (wr_sel == adcic_pkg::SEL_INSEL);
  wire logic wr_bias = wr_en & (wr_sel == adcic_pkg::SEL_BIAS);
  wire logic [1:0] bresp_nxt = (wr_sel == adcic_pkg::SEL_NONE) ? adcic_pkg::RESP_SLVERR : adcic_pkg::RESP_OKAY;

  // read select and data
  wire adcic_pkg::adcic_sel_t rd_sel = reg_sel(i_s_axi_araddr);
  wire logic [adcic_pkg::REG_W-1:0] rd_byte =
    (rd_sel == adcic_pkg::SEL_SRC)   ? src_level_r :
    (rd_sel == adcic_pkg::SEL_AMP)   ? amp_r :
    (rd_sel == adcic_pkg::SEL_INSEL) ? insel_r :
    (rd_sel == adcic_pkg::SEL_BIAS)  ? bias_r :
                                       adcic_pkg::RSVD_VALUE;
  wire logic [1:0] rresp_nxt = (rd_sel == adcic_pkg::SEL_NONE) ? adcic_pkg::RESP_SLVERR : adcic_pkg::RESP_OKAY;

  // write address and data capture, either order
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      awaddr_r  <= '0;
      wbyte_r   <= '0;
      wlane_r   <= 1'b0;
    end
    else if (i_ce)
    begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      awready_r <= ~aw_full_nxt;
      wready_r  <= ~w_full_nxt;
      if (aw_hs)
        awaddr_r <= i_s_axi_awaddr;
      if (w_hs)
      begin
        wbyte_r <= i_s_axi_wdata[adcic_pkg::REG_W-1:0];
        wlane_r <= i_s_axi_wstrb[0];
      end
    end
  end

  // write response, held until accepted
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= adcic_pkg::RESP_OKAY;
    end
    else if (i_ce)
    begin
      bvalid_r <= bvalid_nxt;
      if (wr_fire)
        bresp_r <= bresp_nxt;
    end
  end

  // register storage; reserved amplifier bits kept as written
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      src_level_r <= adcic_pkg::RST_SRC_LEVEL;
      amp_r       <= adcic_pkg::RST_AMP;
      insel_r     <= adcic_pkg::RST_INSEL;
      bias_r      <= adcic_pkg::RST_BIAS;
    end
    else if (i_ce)
    begin
      if (wr_src)
        src_level_r <= wbyte_r;
      if (wr_amp)
        amp_r <= wbyte_r;
      if (wr_insel)
        insel_r <= wbyte_r;
      if (wr_bias)
        bias_r <= wbyte_r;
    end
  end

  // read channel, one read at a time
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= adcic_pkg::RESP_OKAY;
    end
    else if (i_ce)
    begin
      rvalid_r  <= rvalid_nxt;
      arready_r <= ~rvalid_nxt;
      if (ar_hs)
      begin
        rdata_r <= {{(adcic_pkg::DATA_W-adcic_pkg::REG_W){1'b0}}, rd_byte};
        rresp_r <= rresp_nxt;
      end
    end
  end

  // field decode into front end quantities
  logic [adcic_pkg::UA_W-1:0]     dec_src2;
  logic [adcic_pkg::UA_W-1:0]     dec_src1;
  logic [adcic_pkg::GAIN_F_W-1:0] dec_gain;
  logic                           dec_open;
  logic [adcic_pkg::NA_W-1:0]     dec_bo;

  adcic_field_decode i_adcic_field_decode
  (
    .i_src_level (src_level_r),
    .i_amp       (amp_r),
    .i_insel     (insel_r),
    .i_bias      (bias_r),
    .o_src2_ua   (dec_src2),
    .o_src1_ua   (dec_src1),
    .o_gain      (dec_gain),
    .o_all_open  (dec_open),
    .o_bo_na     (dec_bo)
  );

  // front end controls, one cycle behind the registers so every output is a flop
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_second_source_ua      <= '0;
      o_first_source_ua       <= '0;
      o_amp_bypass            <= 1'b0;
      o_gain                  <= adcic_pkg::GAIN_UNITY;
      o_positive_input_select <= adcic_pkg::RST_INSEL[adcic_pkg::POSITIVE_INPUT_SELECT_LSB +: adcic_pkg::MUX_W];
      o_negative_input_select <= adcic_pkg::RST_INSEL[adcic_pkg::NEGATIVE_INPUT_SELECT_LSB +: adcic_pkg::MUX_W];
      o_all_inputs_open       <= 1'b0;
      o_bias_voltage_enable   <= 1'b0;
      o_burnout_polarity      <= 1'b0;
      o_burnout_na            <= '0;
    end
    else if (i_ce)
    begin
      o_second_source_ua      <= dec_src2;
      o_first_source_ua       <= dec_src1;
      o_amp_bypass            <= amp_r[adcic_pkg::BYPASS_BIT];
      o_gain                  <= dec_gain;
      o_positive_input_select <= insel_r[adcic_pkg::POSITIVE_INPUT_SELECT_LSB +: adcic_pkg::MUX_W];
      o_negative_input_select <= insel_r[adcic_pkg::NEGATIVE_INPUT_SELECT_LSB +: adcic_pkg::MUX_W];
      o_all_inputs_open       <= dec_open;
      o_bias_voltage_enable   <= bias_r[adcic_pkg::BIAS_VOLTAGE_ENABLE_BIT];
      o_burnout_polarity      <= bias_r[adcic_pkg::BO_POL_BIT];
      o_burnout_na            <= dec_bo;
    end
  end

  // bus outputs straight from flops
  assign o_s_axi_awready = awready_r;
  assign o_s_axi_wready  = wready_r;
  assign o_s_axi_bvalid  = bvalid_r;
  assign o_s_axi_bresp   = bresp_r;
  assign o_s_axi_arready = arready_r;
  assign o_s_axi_rvalid  = rvalid_r;
  assign o_s_axi_rdata   = rdata_r;
  assign o_s_axi_rresp   = rresp_r;

  // checks on the outputs against the stored codes, and on register writes
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  AST_SRC2_OFF: assert property (
    (i_ce && src_level_r[adcic_pkg::SRC2_LSB +: adcic_pkg::SRC_W] > adcic_pkg::SRC_CODE_MAX)
    |=> o_second_source_ua == '0)
    else $error("second source not off for unused code");

  AST_SRC1_50: assert property (
    (i_ce && src_level_r[adcic_pkg::SRC1_LSB +: adcic_pkg::SRC_W] == 4'h1) |=> o_first_source_ua == 12'h032)
    else $error("first source code 1 not 50 uA");

  AST_RSVD_READ_ZERO: assert property (
    (i_ce && ar_hs && rd_sel == adcic_pkg::SEL_RSVD) |=> (o_s_axi_rvalid && o_s_axi_rdata == '0))
    else $error("reserved register read not zero");

  AST_BYPASS: assert property (
    i_ce |=> o_amp_bypass == $past(amp_r[adcic_pkg::BYPASS_BIT]))
    else $error("bypass output does not follow register");

  AST_GAIN: assert property (
    i_ce |=> o_gain == (adcic_pkg::GAIN_UNITY << $past(amp_r[adcic_pkg::GAIN_LSB +: adcic_pkg::GAIN_W])))
    else $error("gain factor mismatch");

  AST_POS_SEL: assert property (
    i_ce |=> o_positive_input_select == $past(insel_r[adcic_pkg::POSITIVE_INPUT_SELECT_LSB +: adcic_pkg::MUX_W]))
    else $error("positive select does not follow register");

  AST_ALL_OPEN: assert property (
    i_ce |=> o_all_inputs_open == ($past(insel_r[adcic_pkg::NEGATIVE_INPUT_SELECT_LSB +: adcic_pkg::MUX_W]) == adcic_pkg::MUX_OPEN))
    else $error("open flag does not match negative select code");

  AST_BIAS_BITS: assert property (
    i_ce |=> (o_bias_voltage_enable == $past(bias_r[adcic_pkg::BIAS_VOLTAGE_ENABLE_BIT])
              && o_burnout_polarity == $past(bias_r[adcic_pkg::BO_POL_BIT])))
    else $error("bias or polarity output mismatch");

  AST_BURNOUT_10UA: assert property (
    (i_ce && bias_r[adcic_pkg::BO_LSB +: adcic_pkg::BO_W] == 3'h4) |=> o_burnout_na == 14'h2710)
    else $error("burn-out code 4 not 10 uA");

  AST_RSVD_WRITE_IGNORED: assert property (
    (i_ce && wr_fire && wr_sel == adcic_pkg::SEL_RSVD)
    |=> ($stable(src_level_r) && $stable(amp_r) && $stable(insel_r) && $stable(bias_r)))
    else $error("reserved write changed a register");

  AST_WRITE_STORES: assert property (
    (i_ce && wr_insel) |=> insel_r == $past(wbyte_r))
    else $error("input select write not stored");

endmodule

// ===== sim/test_adc_input_config_registers.sv
// self-checking bench for the input configuration register bank
`timescale 1ns/1ns
module test_adc_input_config_registers;
  localparam logic [7:0] A_SRC = {adcic_pkg::IDX_SRC_LEVEL, 2'b00};
  localparam logic [7:0] A_RSV = {adcic_pkg::IDX_RSVD, 2'b00};
  localparam logic [7:0] A_AMP = {adcic_pkg::IDX_AMP, 2'b00};
  localparam logic [7:0] A_SEL = {adcic_pkg::IDX_INSEL, 2'b00};
  localparam logic [7:0] A_BIA = {adcic_pkg::IDX_BIAS, 2'b00};
  logic        core_clk;
  logic        nrst;
  logic        ce;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        rready;
  logic        awready;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic [11:0] src2_ua;
  logic [11:0] src1_ua;
  logic        bypass;
  logic [7:0]  gain;
  logic [3:0]  psel;
  logic [3:0]  nsel;
  logic        all_open;
  logic        bias_en;
  logic        bo_pol;
  logic [13:0] bo_na;
  logic [7:0]  sh [0:3];
  logic [31:0] rs = 32'h00002b09;
  int          fail_count = 0;
  int          compares = 0;

  adcic_regs i_adcic_regs (.i_core_clk(core_clk), .i_nrst(nrst), .i_ce(ce),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .o_second_source_ua(src2_ua), .o_first_source_ua(src1_ua), .o_amp_bypass(bypass), .o_gain(gain),
    .o_positive_input_select(psel), .o_negative_input_select(nsel), .o_all_inputs_open(all_open),
    .o_bias_voltage_enable(bias_en), .o_burnout_polarity(bo_pol), .o_burnout_na(bo_na));

  // free-running core clock, 50 ns period
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // repeatable xorshift source for stimulus and stalls
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // excitation current in microamps, reserved codes are off
  function automatic logic [11:0] ua_of(input logic [3:0] c);
    case (c)
      4'h1: return 12'h032;
      4'h2: return 12'h064;
      4'h3: return 12'h0fa;
      4'h4: return 12'h1f4;
      4'h5: return 12'h2ee;
      4'h6: return 12'h3e8;
      4'h7: return 12'h5dc;
      4'h8: return 12'h7d0;
      4'h9: return 12'h9c4;
      4'ha: return 12'hbb8;
      default: return 12'h000;
    endcase
  endfunction

  // burn-out current in nanoamps, reserved codes give nothing
  function automatic logic [13:0] na_of(input logic [2:0] c);
    case (c)
      3'h1: return 14'h0032;
      3'h2: return 14'h00c8;
      3'h3: return 14'h03e8;
      3'h4: return 14'h2710;
      default: return 14'h0000;
    endcase
  endfunction

  // shadow slot of an address: -1 unmapped, 4 the always-zero register
  function automatic int slot(input logic [7:0] a);
    case (a[7:2])
      adcic_pkg::IDX_SRC_LEVEL: return 0;
      adcic_pkg::IDX_AMP: return 1;
      adcic_pkg::IDX_INSEL: return 2;
      adcic_pkg::IDX_BIAS: return 3;
      adcic_pkg::IDX_RSVD: return 4;
      default: return -1;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one write; address and data offered together, bready held back a random while
  task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int   k;
    int   n;
    int   st;
    logic aw_ok;
    logic w_ok;
    k = slot(a);
    st = int'(rnd() % 3);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    n = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok) && n < 50)
    begin
      @(posedge core_clk);
      n++;
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    repeat (st) @(posedge core_clk);
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (bvalid !== 1'b1 && n < 50);
    // a write that never answers counts against the run
    if (bvalid !== 1'b1)
      fail_count++;
    bready <= 1'b0;
    chk(32'(bresp), (k < 0) ? 32'h2 : 32'h0);
    if (k >= 0 && k < 4 && s[0])
      sh[k] = d[7:0];
  endtask

  // one read; rready held back a random while, answer taken at the handshake edge
  task automatic get(input logic [7:0] a);
    int k;
    int n;
    int st;
    k = slot(a);
    st = int'(rnd() % 3);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    repeat (st) @(posedge core_clk);
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (rvalid !== 1'b1 && n < 50);
    // a read that never answers counts against the run
    if (rvalid !== 1'b1)
      fail_count++;
    rready <= 1'b0;
    chk(rdata, (k < 0 || k == 4) ? 32'h0 : {24'h0, sh[k]});
    chk(32'(rresp), (k < 0) ? 32'h2 : 32'h0);
  endtask

  // read every address around the bank, then the front end outputs
  task automatic verify();
    int i;
    for (i = 'h0d; i <= 'h13; i++)
      get({i[5:0], 2'b00});
    chk(32'(src2_ua), 32'(ua_of(sh[0][7:4])));
    chk(32'(src1_ua), 32'(ua_of(sh[0][3:0])));
    chk(32'(bypass), 32'(sh[1][7]));
    chk(32'(gain), 32'(8'h01 << sh[1][2:0]));
    chk(32'(psel), 32'(sh[2][7:4]));
    chk(32'(nsel), 32'(sh[2][3:0]));
    chk(32'(all_open), 32'(sh[2][3:0] == 4'he));
    chk(32'(bias_en), 32'(sh[3][4]));
    chk(32'(bo_pol), 32'(sh[3][3]));
    chk(32'(bo_na), 32'(na_of(sh[3][2:0])));
  endtask

  // hang guard, well beyond the expected run length
  initial
  begin
    repeat (40000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end

  // main sequence: reset, code sweeps, refusals, then random traffic
  initial
  begin
    logic [31:0] r;
    logic [31:0] d;
    logic [7:0]  a;
    int          c;
    nrst = 1'b0;
    ce = 1'b1;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    sh[0] = 8'h00;
    sh[1] = 8'h00;
    sh[2] = 8'hff;
    sh[3] = 8'h00;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    verify();
    for (c = 0; c < 16; c++)
    begin
      put(A_SRC, 32'({c[3:0], ~c[3:0]}), 4'h1);
      verify();
    end
    for (c = 0; c < 16; c++)
    begin
      put(A_AMP, 32'({c[3], 4'h0, c[2:0]}), 4'h1);
      verify();
    end
    for (c = 0; c < 16; c++)
    begin
      put(A_SEL, 32'({c[3:0], 4'(15 - c)}), 4'h1);
      verify();
    end
    for (c = 0; c < 32; c++)
    begin
      put(A_BIA, 32'({3'h0, c[4:0]}), 4'h1);
      verify();
    end
    put(A_RSV, 32'hffffffff, 4'hf);
    verify();
    put(A_SEL, 32'h0000005a, 4'he);
    verify();
    // clock enable low: an offered write must not be taken or answered
    ce <= 1'b0;
    awaddr <= A_BIA;
    awvalid <= 1'b1;
    wdata <= 32'h0000001f;
    wstrb <= 4'h1;
    wvalid <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk(32'(bvalid), 32'h0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    ce <= 1'b1;
    @(posedge core_clk);
    verify();
    for (c = 0; c < 60; c++)
    begin
      r = rnd();
      d = rnd();
      a = {6'(6'h0d + 6'(r[10:8] % 3'h7)), r[1:0]};
      if (a[7:2] == adcic_pkg::IDX_AMP)
        d[6:3] = 4'h0;
      put(a, d, r[15:12]);
      verify();
    end
    print_verdict();
  end
endmodule
